// >>> core/vcsl_sync.sv
`timescale 1ns/1ps
module vcsl_sync (
  // clock
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // data
  input wire logic din,
  output logic dout
);
  logic stage1;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else if (clk_en) begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// >>> core/vcsl_top.sv
`timescale 1ns/1ps
module vcsl_top (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // front panel
  input wire logic vector_mode,
  input wire logic [1:0] chan_sel,
  input wire logic [1:0] fmt_sel,
  // sweep and display controller
  input wire logic sweep_end_sync,
  input wire logic saved_mode,
  input wire logic beam_blank_override,
  // channel drive
  output logic ch1_live_en,
  output logic ch2_live_en,
  output logic vector_plot_line,
  output logic chopping_allow_n,
  // saved path
  output logic saved_waveform_enable,
  output logic saved_display_select_n,
  output logic sweep_sep_disable,
  output logic live_sweep_block,
  // blanking
  output logic slice_transition_blank
);
  logic s_vec, s_sweep, s_saved, s_bbo;
  logic [1:0] s_chan, s_fmt;
  logic chop_osc;
  logic [3:0] chop_cnt;
  logic sel_q;
  logic sel_q_prev;
  logic [3:0] blank_cnt;
  logic set_n, rst_n_ff;
  logic gated_clk, gated_clk_d;
  logic toggle_edge;
  logic next_allow_n;

  // format decode shared by the assertions below
  function automatic logic dual_fmt(input logic vec, input logic [1:0] chan, input logic [1:0] fmt,
    input logic [1:0] want);
    return !vec && chan == vcsl_pkg::vcsl_ch_dual && fmt == want;
  endfunction

  function automatic logic single_chan(input logic vec, input logic [1:0] chan, input logic [1:0] want);
    return !vec && chan == want;
  endfunction

  // pins cross from the panel: two flops each
  vcsl_sync u_s0 (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .din(vector_mode), .dout(s_vec));
  vcsl_sync u_s1 (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .din(sweep_end_sync), .dout(s_sweep));
  vcsl_sync u_s2 (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .din(saved_mode), .dout(s_saved));
  vcsl_sync u_s3 (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .din(beam_blank_override), .dout(s_bbo));
  vcsl_sync u_s4 (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .din(chan_sel[0]), .dout(s_chan[0]));
  vcsl_sync u_s5 (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .din(chan_sel[1]), .dout(s_chan[1]));
  vcsl_sync u_s6 (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .din(fmt_sel[0]), .dout(s_fmt[0]));
  vcsl_sync u_s7 (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .din(fmt_sel[1]), .dout(s_fmt[1]));

  // set/reset decode, active low; dual formats only count in dual setting
  always_comb begin
    set_n = 1'b1;
    rst_n_ff = 1'b1;
    next_allow_n = 1'b1;
    if (!s_vec) begin
      case (s_chan)
        vcsl_pkg::vcsl_ch_one: begin
          set_n = 1'b0;
        end
        vcsl_pkg::vcsl_ch_two: begin
          rst_n_ff = 1'b0;
        end
        vcsl_pkg::vcsl_ch_dual: begin
          case (s_fmt)
            vcsl_pkg::vcsl_fmt_sum: begin
              set_n = 1'b0;
              rst_n_ff = 1'b0;
            end
            vcsl_pkg::vcsl_fmt_slice: begin
              next_allow_n = 1'b0;
            end
            default: begin
              next_allow_n = 1'b1;
            end
          endcase
        end
        default: begin
          set_n = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      chopping_allow_n <= 1'b1;
      vector_plot_line <= 1'b0;
    end else if (clk_en) begin
      chopping_allow_n <= next_allow_n;
      vector_plot_line <= s_vec;
    end
  end

  // chop oscillator; stopped means output held high
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      chop_osc <= 1'b1;
      chop_cnt <= vcsl_pkg::count_zero;
    end else if (clk_en) begin
      if (chopping_allow_n) begin
        chop_osc <= 1'b1;
        chop_cnt <= vcsl_pkg::count_zero;
      end else if (chop_cnt == vcsl_pkg::chop_half) begin
        chop_osc <= ~chop_osc;
        chop_cnt <= vcsl_pkg::count_zero;
      end else begin
        chop_cnt <= chop_cnt + vcsl_pkg::count_one;
      end
    end
  end

  // chop_osc is the inverted side of the oscillator: stopped means high, so the nand passes inverted sync
  assign gated_clk = ~(chop_osc & s_sweep);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      // gate is high in reset since s_sweep resets low; a low reset value would fake an edge
      gated_clk_d <= 1'b1;
    end else if (clk_en) begin
      gated_clk_d <= gated_clk;
    end
  end
  assign toggle_edge = gated_clk & ~gated_clk_d;

  // select flop: overrides win over toggling
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= 1'b1;
      sel_q_prev <= 1'b1;
    end else if (clk_en) begin
      sel_q_prev <= sel_q;
      if (!set_n || !rst_n_ff) begin
        sel_q <= !set_n;
      end else if (toggle_edge) begin
        sel_q <= ~sel_q;
      end
    end
  end

  // sum drives both halves high; held separately since sel_q alone can't
  logic both_on;
  assign both_on = !set_n && !rst_n_ff;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ch1_live_en <= 1'b0;
      ch2_live_en <= 1'b0;
    end else if (clk_en) begin
      if (s_saved) begin
        ch1_live_en <= 1'b0;
        ch2_live_en <= 1'b0;
      end else begin
        ch1_live_en <= sel_q | both_on;
        ch2_live_en <= ~sel_q | both_on;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      saved_waveform_enable <= 1'b0;
      saved_display_select_n <= 1'b1;
      sweep_sep_disable <= 1'b0;
      live_sweep_block <= 1'b0;
    end else if (clk_en) begin
      saved_waveform_enable <= s_saved;
      saved_display_select_n <= ~s_saved;
      sweep_sep_disable <= s_saved;
      live_sweep_block <= s_saved;
    end
  end

  // blanking: short low pulse per toggle, active low toward intensity path
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      blank_cnt <= vcsl_pkg::count_zero;
      slice_transition_blank <= 1'b1;
    end else if (clk_en) begin
      if (sel_q != sel_q_prev) begin
        blank_cnt <= vcsl_pkg::blank_cycles;
      end else if (blank_cnt != vcsl_pkg::count_zero) begin
        blank_cnt <= blank_cnt - vcsl_pkg::count_one;
      end
      slice_transition_blank <= s_bbo || !((sel_q != sel_q_prev) || (blank_cnt > vcsl_pkg::count_one));
    end
  end

  // assertions
  saved_kills_live_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && s_saved |=> !ch1_live_en && !ch2_live_en) else $error("live enable in saved mode");
  saved_enable_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> saved_waveform_enable == $past(s_saved)) else $error("saved enable wrong");
  saved_sel_a: assert property (@(posedge clock) disable iff (sys_rst)
    saved_waveform_enable |-> !saved_display_select_n) else $error("saved select not low");
  sep_block_a: assert property (@(posedge clock) disable iff (sys_rst)
    saved_waveform_enable |-> sweep_sep_disable && live_sweep_block) else $error("sweep not blocked");
  override_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && s_bbo |=> slice_transition_blank) else $error("blank not held high");
  sequence toggled_s;
    clk_en && (sel_q != sel_q_prev);
  endsequence
  toggle_blank_a: assert property (@(posedge clock) disable iff (sys_rst)
    toggled_s and !s_bbo |=> !slice_transition_blank) else $error("no blank on toggle");
  sum_both_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && both_on && !s_saved |=> ch1_live_en && ch2_live_en) else $error("sum not both");
  ch1_only_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !set_n && rst_n_ff |=> sel_q) else $error("ch1 set failed");
  ch2_only_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && set_n && !rst_n_ff |=> !sel_q) else $error("ch2 reset failed");
  toggle_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && set_n && rst_n_ff && toggle_edge |=> sel_q != $past(sel_q)) else $error("no toggle");
  osc_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && chopping_allow_n |=> chop_osc) else $error("oscillator not stopped");
  live_pass_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !s_saved && !both_on |=> ch1_live_en == $past(sel_q) && ch2_live_en == !$past(sel_q))
    else $error("live pass wrong");

  // decode checks
  vec_line_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> vector_plot_line == $past(s_vec))
    else $error("vector line wrong");

  vec_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_vec |-> set_n && rst_n_ff)
    else $error("set or reset active in vector mode");

  vec_chop_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && s_vec |=> chopping_allow_n)
    else $error("chop allowed in vector mode");

  ch1_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
    single_chan(s_vec, s_chan, vcsl_pkg::vcsl_ch_one) |-> !set_n && rst_n_ff)
    else $error("ch1 decode wrong");

  ch2_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
    single_chan(s_vec, s_chan, vcsl_pkg::vcsl_ch_two) |-> set_n && !rst_n_ff)
    else $error("ch2 decode wrong");

  sum_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
    dual_fmt(s_vec, s_chan, s_fmt, vcsl_pkg::vcsl_fmt_sum) |-> both_on)
    else $error("sum decode wrong");

  slice_allow_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && dual_fmt(s_vec, s_chan, s_fmt, vcsl_pkg::vcsl_fmt_slice) |=> !chopping_allow_n)
    else $error("chop not allowed in slice");

  alt_allow_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !dual_fmt(s_vec, s_chan, s_fmt, vcsl_pkg::vcsl_fmt_slice) |=> chopping_allow_n)
    else $error("chop allowed outside slice");

  chop_range_a: assert property (@(posedge clock) disable iff (sys_rst)
    chop_cnt <= vcsl_pkg::chop_half)
    else $error("chop count out of range");

  chop_flip_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !chopping_allow_n && chop_cnt == vcsl_pkg::chop_half |=> chop_osc != $past(chop_osc))
    else $error("chop did not flip");

  chop_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !chopping_allow_n && chop_cnt != vcsl_pkg::chop_half |=> chop_osc == $past(chop_osc))
    else $error("chop flipped early");

  // clocking of the select flop
  sequence chop_fall_s;
    clk_en && chop_osc && s_sweep ##1 clk_en && !chop_osc && s_sweep && set_n && rst_n_ff;
  endsequence

  chop_toggle_a: assert property (@(posedge clock) disable iff (sys_rst)
    chop_fall_s |=> sel_q != $past(sel_q))
    else $error("chop edge did not toggle");

  sequence sweep_fall_s;
    clk_en && chop_osc && s_sweep ##1 clk_en && chop_osc && !s_sweep && set_n && rst_n_ff;
  endsequence

  sweep_toggle_a: assert property (@(posedge clock) disable iff (sys_rst)
    sweep_fall_s |=> sel_q != $past(sel_q))
    else $error("sweep end did not toggle");

  holdoff_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !s_sweep && gated_clk_d && set_n && rst_n_ff |=> sel_q == $past(sel_q))
    else $error("toggle during holdoff");

  no_edge_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && set_n && rst_n_ff && !toggle_edge |=> sel_q == $past(sel_q))
    else $error("toggle without edge");

  // live enables
  ch1_on_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !s_saved && sel_q |=> ch1_live_en)
    else $error("ch1 not enabled");

  ch1_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !s_saved && !sel_q && !both_on |=> !ch1_live_en)
    else $error("ch1 not disabled");

  ch2_on_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !s_saved && !sel_q |=> ch2_live_en)
    else $error("ch2 not enabled");

  ch2_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !s_saved && sel_q && !both_on |=> !ch2_live_en)
    else $error("ch2 not disabled");

  live_mode_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !s_saved |=> !saved_waveform_enable && saved_display_select_n
      && !sweep_sep_disable && !live_sweep_block)
    else $error("saved path active in live mode");

  saved_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && s_saved |=> !saved_display_select_n)
    else $error("saved select high in saved mode");

  saved_sweep_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && s_saved |=> live_sweep_block && sweep_sep_disable)
    else $error("live sweep passes in saved mode");

  sel_needs_saved_a: assert property (@(posedge clock) disable iff (sys_rst)
    !saved_display_select_n |-> saved_waveform_enable)
    else $error("saved select without saved enable");

  // blanking
  blank_range_a: assert property (@(posedge clock) disable iff (sys_rst)
    blank_cnt <= vcsl_pkg::blank_cycles)
    else $error("blank count out of range");

  blank_second_a: assert property (@(posedge clock) disable iff (sys_rst)
    toggled_s ##1 (clk_en && !s_bbo) |=> !slice_transition_blank)
    else $error("blank too short");

  blank_end_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !s_bbo && sel_q == sel_q_prev && blank_cnt <= vcsl_pkg::count_one |=> slice_transition_blank)
    else $error("blank too long");

  // frozen while the enable is low
  freeze_a: assert property (@(posedge clock) disable iff (sys_rst)
    !clk_en |=> $stable(sel_q) && $stable(chop_cnt) && $stable(ch1_live_en) && $stable(slice_transition_blank))
    else $error("state moved while frozen");
endmodule

// >>> shared/vcsl_pkg.sv
package vcsl_pkg;
  typedef enum logic [1:0] {
    vcsl_ch_one,
    vcsl_ch_two,
    vcsl_ch_dual
  } vcsl_chan_e;
  typedef enum logic [1:0] {
    vcsl_fmt_sum,
    vcsl_fmt_alt,
    vcsl_fmt_slice
  } vcsl_fmt_e;
  localparam int unsigned clock_hz = 10_000_000;
  localparam int unsigned blank_ns = 300;
  localparam int unsigned blank_cycles_raw = (blank_ns * (clock_hz / 1_000_000) + 999) / 1000;
  localparam logic [3:0] blank_cycles = 4'(blank_cycles_raw < 1 ? 1 : blank_cycles_raw);
  localparam int unsigned chop_half_cycles = 8;
  localparam logic [3:0] chop_half = 4'(chop_half_cycles - 1);
  localparam logic [3:0] count_zero = 4'h0;
  localparam logic [3:0] count_one = 4'h1;
endpackage

// >>> tb/testbench.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module testbench;
  logic clock, sys_rst, clk_en, want_vec, want_saved, want_ovr, sweep_on;
  logic [1:0] want_chan, want_fmt, chan_sel, fmt_sel;
  logic vector_mode, sweep_end_sync, saved_mode, beam_blank_override;
  logic ch1_live_en, ch2_live_en, vector_plot_line, chopping_allow_n;
  logic saved_waveform_enable, saved_display_select_n, sweep_sep_disable, live_sweep_block;
  logic slice_transition_blank;
  int miscompares, n_tests, cycles, flips, lows, clashes;
  vcsl_panel panel (.clock(clock), .want_vec(want_vec), .want_chan(want_chan), .want_fmt(want_fmt),
    .want_saved(want_saved), .want_ovr(want_ovr), .sweep_on(sweep_on), .vector_mode(vector_mode),
    .chan_sel(chan_sel), .fmt_sel(fmt_sel), .sweep_end_sync(sweep_end_sync), .saved_mode(saved_mode),
    .beam_blank_override(beam_blank_override));
  vcsl_top dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .vector_mode(vector_mode),
    .chan_sel(chan_sel), .fmt_sel(fmt_sel), .sweep_end_sync(sweep_end_sync), .saved_mode(saved_mode),
    .beam_blank_override(beam_blank_override), .ch1_live_en(ch1_live_en), .ch2_live_en(ch2_live_en),
    .vector_plot_line(vector_plot_line), .chopping_allow_n(chopping_allow_n),
    .saved_waveform_enable(saved_waveform_enable), .saved_display_select_n(saved_display_select_n),
    .sweep_sep_disable(sweep_sep_disable), .live_sweep_block(live_sweep_block),
    .slice_transition_blank(slice_transition_blank));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // panel settles, then two sync flops and the decode: 10 cycles is ample
  task set_mode(input logic [1:0] c, input logic [1:0] f, input logic s, input logic o);
    @(negedge clock);
    want_chan = c;
    want_fmt = f;
    want_saved = s;
    want_ovr = o;
    repeat (10) @(negedge clock);
  endtask
  task watch(input int n);
    logic prev;
    flips = 0;
    lows = 0;
    clashes = 0;
    repeat (n) begin
      prev = ch1_live_en;
      @(negedge clock);
      if (ch1_live_en !== prev) flips++;
      if (slice_transition_blank === 1'b0) lows++;
      if (ch1_live_en === ch2_live_en) clashes++;
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    {miscompares, n_tests, cycles} = '0;
    {sys_rst, clk_en, want_vec, want_saved, want_ovr, sweep_on} = 6'b110000;
    {want_chan, want_fmt} = 4'h0;
    repeat (8) @(negedge clock);
    `CHK("blank in reset", 1'b1, slice_transition_blank)
    sys_rst = 1'b0;
    set_mode(2'h0, 2'h0, 1'b0, 1'b0);
    `CHK("ch1 only ch1", 1'b1, ch1_live_en)
    `CHK("ch1 only ch2", 1'b0, ch2_live_en)
    `CHK("vector line", 1'b0, vector_plot_line)
    $display("test channel one done");
    set_mode(2'h1, 2'h0, 1'b0, 1'b0);
    `CHK("ch2 only ch1", 1'b0, ch1_live_en)
    `CHK("ch2 only ch2", 1'b1, ch2_live_en)
    $display("test channel two done");
    set_mode(2'h2, 2'h0, 1'b0, 1'b0);
    `CHK("sum enables", 2'h3, {ch1_live_en, ch2_live_en})
    $display("test sum done");
    set_mode(2'h2, 2'h2, 1'b0, 1'b0);
    `CHK("slice chop allow", 1'b0, chopping_allow_n)
    watch(64);
    `CHK("slice toggles", 1'b1, flips inside {[3:5]})
    `CHK("slice exclusive", 0, clashes)
    `CHK("slice blanking", 1'b1, lows >= 3)
    set_mode(2'h2, 2'h2, 1'b0, 1'b1);
    watch(64);
    `CHK("override blank", 0, lows)
    set_mode(2'h2, 2'h2, 1'b0, 1'b0);
    clk_en = 1'b0;
    watch(40);
    clk_en = 1'b1;
    `CHK("frozen select", 0, flips)
    $display("test time slice done");
    set_mode(2'h2, 2'h1, 1'b0, 1'b0);
    `CHK("alt chop allow", 1'b1, chopping_allow_n)
    watch(20);
    `CHK("alt idle", 0, flips)
    sweep_on = 1'b1;
    watch(70);
    sweep_on = 1'b0;
    `CHK("alt sweep swaps", 2, flips)
    $display("test alternate done");
    want_vec = 1'b1;
    set_mode(2'h2, 2'h2, 1'b0, 1'b0);
    `CHK("vector line high", 1'b1, vector_plot_line)
    `CHK("vector chop stopped", 1'b1, chopping_allow_n)
    want_vec = 1'b0;
    $display("test vector done");
    set_mode(2'h1, 2'h0, 1'b1, 1'b0);
    `CHK("saved live off", 2'h0, {ch1_live_en, ch2_live_en})
    `CHK("saved enable", 1'b1, saved_waveform_enable)
    `CHK("saved sep off", 2'h3, {sweep_sep_disable, live_sweep_block})
    `CHK("saved select", 1'b0, saved_display_select_n)
    set_mode(2'h1, 2'h0, 1'b0, 1'b0);
    `CHK("live restored", 2'h1, {ch1_live_en, ch2_live_en})
    `CHK("live select", 1'b1, saved_display_select_n)
    $display("test saved done");
    wrap_up();
  end
endmodule

// >>> tb/vcsl_panel.sv
`timescale 1ns/1ps
module vcsl_panel (
  // clock
  input wire logic clock,
  // requests from the bench
  input wire logic want_vec,
  input wire logic [1:0] want_chan,
  input wire logic [1:0] want_fmt,
  input wire logic want_saved,
  input wire logic want_ovr,
  input wire logic sweep_on,
  // panel and controller lines
  output logic vector_mode,
  output logic [1:0] chan_sel,
  output logic [1:0] fmt_sel,
  output logic sweep_end_sync,
  output logic saved_mode,
  output logic beam_blank_override
);
  logic [4:0] sweep_count;
  initial begin
    vector_mode = 1'b0;
    chan_sel = 2'h0;
    fmt_sel = 2'h0;
    sweep_end_sync = 1'b1;
    saved_mode = 1'b0;
    beam_blank_override = 1'b0;
    sweep_count = 5'h00;
  end
  always @(negedge clock) begin
    vector_mode <= want_vec;
    chan_sel <= want_chan;
    // format switch only moves while want_chan asks for dual, on the same edge that chan_sel takes it
    if (want_chan == 2'h2) begin
      fmt_sel <= want_fmt;
    end
    saved_mode <= want_saved;
    beam_blank_override <= want_ovr;
    sweep_count <= sweep_on ? sweep_count + 5'h01 : 5'h00;
    // holdoff kept 4 cycles long so the two-flop synchroniser sees it
    sweep_end_sync <= !(sweep_on && sweep_count >= 5'h1c);
  end
endmodule
